// [verilog/e1_rx_alarm_pkg.sv]
// Package: register map, field positions and counts for the E1 receive alarm block
package e1_rx_alarm_pkg;

    // ************************************************************
    // Register offsets and reset values
    // ************************************************************
    localparam logic [7:0] ALARM_STATUS_ADDR = 8'h06;
    localparam logic [7:0] IRQ_MASK_ADDR     = 8'h16;
    localparam logic [7:0] SYNC_STATUS_ADDR  = 8'h1E;
    localparam logic [7:0] REG_RESET         = 8'h00;

    // ************************************************************
    // Alarm status bit positions
    // ************************************************************
    localparam int ALM_SA1  = 7;
    localparam int ALM_DMA  = 6;
    localparam int ALM_SA0  = 5;
    localparam int ALM_SLIP = 4;
    localparam int ALM_UA1  = 3;
    localparam int ALM_RRA  = 2;
    localparam int ALM_RCL  = 1;
    localparam int ALM_LOS  = 0;

    // ************************************************************
    // Timing and detection counts
    // ************************************************************
    localparam int SYS_CLK_KHZ      = 100000;
    localparam int SEARCH_TMO_MS    = 8;
    localparam int SEARCH_TMO_CYC   = SEARCH_TMO_MS * SYS_CLK_KHZ;
    localparam int SEARCH_CNT_W     = 6;
    localparam int TS16_ZERO_MIN    = 3;
    localparam int UA1_WINDOW_BITS  = 512;
    localparam int UA1_ZERO_MIN     = 3;
    localparam int RCL_ZERO_RUN     = 255;
    localparam int RCL_WINDOW_BITS  = 255;
    localparam int RCL_ONES_MIN     = 32;
    localparam int RRA_RUN          = 3;

    // ************************************************************
    // Strobes and levels from the receive framer
    // ************************************************************
    typedef struct packed {
        logic bit_en;        // One recovered line bit this cycle
        logic bit_val;       // Value of that bit
        logic ts16_bit;      // Bit lies in time slot 16
        logic mf_start;      // Multiframe boundary, never with bit_en
        logic ts16_b6_en;    // Bit 6 of TS16 in frame 0 is on bit_val
        logic nfas_b3_en;    // Bit 3 of non-align frame is on bit_val
        logic slip;          // Elastic store repeated or deleted a frame
        logic sync_loss;     // Framer not aligned
    } rx_line_s;

    typedef struct packed {
        logic frame_search;  // Hunting at FAS level
        logic sig_search;    // Hunting for CAS multiframe word
        logic check_search;  // Hunting for CRC4 multiframe word
        logic check_aligned; // Pulse: CRC4 multiframe alignment found
    } sync_state_s;

endpackage : e1_rx_alarm_pkg

// [verilog/e1_receive_alarm_sync_status.sv]
// E1 receive alarm detector, synchronizer status and CRC4 search counter
module e1_receive_alarm_sync_status #(
    parameter int SEARCH_TMO_CYCLES = e1_rx_alarm_pkg::SEARCH_TMO_CYC
) (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    // Parallel register port
    input  wire logic [7:0]                    reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [7:0]                    reg_wdata,
    output logic      [7:0]                    reg_rdata,
    // Receive framer side
    input  wire e1_rx_alarm_pkg::rx_line_s     rx_line,
    input  wire e1_rx_alarm_pkg::sync_state_s  sync_state,
    input  wire logic                          check_framing_enable,
    // Interrupt
    output logic                               alarm_irq_out
);

    // ************************************************************
    // CRC4 multiframe search timer and counter
    // ************************************************************
    localparam int SEARCH_CNT_W_L = e1_rx_alarm_pkg::SEARCH_CNT_W;
    logic [SEARCH_CNT_W_L-1:0] search_cnt;
    logic [31:0] tmo_cnt;
    wire         hunting     = check_framing_enable && sync_state.check_search;
    wire         tmo_hit     = hunting && (tmo_cnt == 32'(SEARCH_TMO_CYCLES - 1));

    // Timer runs only while hunting, restarts on every timeout
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !hunting || tmo_hit) begin
            tmo_cnt <= '0;
        end else begin
            tmo_cnt <= tmo_cnt + 32'd1;
        end
    end

    // Counter: clear on disable or alignment, step on timeout, wrapping past 63
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !check_framing_enable) begin
            search_cnt <= '0;
        end else if (sync_state.check_aligned) begin
            search_cnt <= '0;
        end else if (tmo_hit) begin
            search_cnt <= search_cnt + 6'd1;
        end
    end

    // Live synchronizer status, bit 1 of the counter is hidden
    wire [7:0] sync_search_status = {search_cnt[5:2], search_cnt[0],
                                     sync_state.frame_search,
                                     sync_state.sig_search,
                                     sync_state.check_search};

    // ************************************************************
    // Time slot 16 multiframe evaluators
    // ************************************************************
    localparam int TS16_ZERO_MIN_L = e1_rx_alarm_pkg::TS16_ZERO_MIN;
    logic [7:0] ts16_zeros;
    logic       ts16_any_one;
    logic       ts16_all_ones_alarm;
    logic       ts16_all_zeros_alarm;
    wire        ts16_bit_en = rx_line.bit_en && rx_line.ts16_bit;

    // Counts gathered through the multiframe, judged at its boundary
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ts16_zeros           <= '0;
            ts16_any_one         <= 1'b0;
            ts16_all_ones_alarm  <= 1'b0;
            ts16_all_zeros_alarm <= 1'b0;
        end else if (rx_line.mf_start) begin
            ts16_all_ones_alarm  <= (ts16_zeros < 8'(TS16_ZERO_MIN_L));
            ts16_all_zeros_alarm <= !ts16_any_one;
            ts16_zeros           <= '0;
            ts16_any_one         <= 1'b0;
        end else if (ts16_bit_en) begin
            if (!rx_line.bit_val && ts16_zeros != 8'hFF) begin
                ts16_zeros <= ts16_zeros + 8'd1;
            end
            ts16_any_one <= ts16_any_one | rx_line.bit_val;
        end
    end

    // Distant multiframe alarm with two-in-a-row hysteresis
    logic last_b6;
    logic distant_multiframe_alarm;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            last_b6                  <= 1'b0;
            distant_multiframe_alarm <= 1'b0;
        end else if (rx_line.ts16_b6_en) begin
            last_b6 <= rx_line.bit_val;
            if (rx_line.bit_val && last_b6) begin
                distant_multiframe_alarm <= 1'b1;
            end else if (!rx_line.bit_val && !last_b6) begin
                distant_multiframe_alarm <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Remote alarm, unframed ones and carrier loss
    // ************************************************************
    localparam int RRA_RUN_L = e1_rx_alarm_pkg::RRA_RUN;
    logic [1:0] rra_ones;
    logic [1:0] rra_zeros;
    logic       remote_alarm_flag;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rra_ones          <= '0;
            rra_zeros         <= '0;
            remote_alarm_flag <= 1'b0;
        end else if (rx_line.nfas_b3_en) begin
            rra_ones  <= rx_line.bit_val ? ((rra_ones == 2'd2) ? 2'd2 : rra_ones + 2'd1) : 2'd0;
            rra_zeros <= rx_line.bit_val ? 2'd0 : ((rra_zeros == 2'd2) ? 2'd2 : rra_zeros + 2'd1);
            if (rx_line.bit_val && rra_ones == 2'(RRA_RUN_L - 1)) begin
                remote_alarm_flag <= 1'b1;
            end else if (!rx_line.bit_val && rra_zeros == 2'(RRA_RUN_L - 1)) begin
                remote_alarm_flag <= 1'b0;
            end
        end
    end

    // Unframed ones judged over fixed 512-bit windows
    logic [8:0] ua1_bits;
    logic [1:0] ua1_zeros;
    logic       unframed_ones_alarm;
    wire        ua1_last  = rx_line.bit_en && (ua1_bits == 9'(e1_rx_alarm_pkg::UA1_WINDOW_BITS - 1));
    wire  [1:0] ua1_total = (!rx_line.bit_val && ua1_zeros != 2'd3) ? ua1_zeros + 2'd1 : ua1_zeros;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ua1_bits            <= '0;
            ua1_zeros           <= '0;
            unframed_ones_alarm <= 1'b0;
        end else if (rx_line.bit_en) begin
            ua1_bits  <= ua1_bits + 9'd1;
            ua1_zeros <= ua1_last ? 2'd0 : ua1_total;
            if (ua1_last) begin
                unframed_ones_alarm <= (ua1_total < 2'(e1_rx_alarm_pkg::UA1_ZERO_MIN));
            end
        end
    end

    // Carrier loss: zero run sets, ones density over 255 bits clears
    logic [7:0] zero_run;
    logic [7:0] rcl_bits;
    logic [5:0] rcl_ones;
    logic       carrier_loss_flag;
    wire        rcl_last = rx_line.bit_en && (rcl_bits == 8'(e1_rx_alarm_pkg::RCL_WINDOW_BITS - 1));
    wire  [5:0] rcl_total = (rx_line.bit_val && rcl_ones != 6'h3F) ? rcl_ones + 6'd1 : rcl_ones;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            zero_run          <= '0;
            rcl_bits          <= '0;
            rcl_ones          <= '0;
            carrier_loss_flag <= 1'b0;
        end else if (rx_line.bit_en) begin
            zero_run <= rx_line.bit_val ? 8'd0 : ((zero_run == 8'hFF) ? 8'hFF : zero_run + 8'd1);
            rcl_bits <= rcl_last ? 8'd0 : rcl_bits + 8'd1;
            rcl_ones <= rcl_last ? 6'd0 : rcl_total;
            if (!rx_line.bit_val && zero_run == 8'(e1_rx_alarm_pkg::RCL_ZERO_RUN - 1)) begin
                carrier_loss_flag <= 1'b1;
            end else if (rcl_last && rcl_total >= 6'(e1_rx_alarm_pkg::RCL_ONES_MIN)) begin
                carrier_loss_flag <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Latched alarm status, mask write and interrupt
    // ************************************************************
    logic [7:0] alarm_latch;
    logic [7:0] receive_alarm_status;
    logic [7:0] alarm_irq_mask;
    wire  [7:0] alarm_cond = {ts16_all_ones_alarm, distant_multiframe_alarm,
                              ts16_all_zeros_alarm, rx_line.slip,
                              unframed_ones_alarm, remote_alarm_flag,
                              carrier_loss_flag, rx_line.sync_loss};
    wire        wr_status = reg_wr && (reg_addr == e1_rx_alarm_pkg::ALARM_STATUS_ADDR);
    wire        wr_mask   = reg_wr && (reg_addr == e1_rx_alarm_pkg::IRQ_MASK_ADDR);
    wire  [7:0] clr_bits  = wr_status ? reg_wdata : 8'h00;

    // Per bit: refresh read copy and clear on mask one; new event wins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            alarm_latch          <= e1_rx_alarm_pkg::REG_RESET;
            receive_alarm_status <= e1_rx_alarm_pkg::REG_RESET;
            alarm_irq_mask       <= e1_rx_alarm_pkg::REG_RESET;
        end else begin
            alarm_latch          <= (alarm_latch & ~clr_bits) | alarm_cond;
            receive_alarm_status <= (receive_alarm_status & ~clr_bits)
                                    | (alarm_latch & clr_bits);
            if (wr_mask) begin
                alarm_irq_mask <= reg_wdata;
            end
        end
    end

    assign alarm_irq_out = |(alarm_latch & alarm_irq_mask);

    // Read data registered on the read strobe; unmapped reads give zero
    wire [7:0] rd_sel = (reg_addr == e1_rx_alarm_pkg::ALARM_STATUS_ADDR) ? receive_alarm_status :
                        (reg_addr == e1_rx_alarm_pkg::IRQ_MASK_ADDR)     ? alarm_irq_mask :
                        (reg_addr == e1_rx_alarm_pkg::SYNC_STATUS_ADDR)  ? sync_search_status :
                        8'h00;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= e1_rx_alarm_pkg::REG_RESET;
        end else if (reg_rd) begin
            reg_rdata <= rd_sel;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    // Frame 0 bit 6 set again right after a multiframe that had it set
    sequence s_b6_repeat;
        rx_line.ts16_b6_en && rx_line.bit_val && last_b6;
    endsequence

    a_search_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tmo_hit && check_framing_enable && !sync_state.check_aligned
        |=> search_cnt == $past(search_cnt) + 6'd1)
        else $error("search counter missed a timeout step");
    a_search_align: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sync_state.check_aligned |=> search_cnt == 6'd0)
        else $error("search counter not cleared on alignment");
    a_search_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !check_framing_enable [*2] |-> search_cnt == 6'd0)
        else $error("search counter not held clear while disabled");
    a_ssr_toggle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tmo_hit && check_framing_enable && !sync_state.check_aligned
        |=> sync_search_status[3] != $past(sync_search_status[3]))
        else $error("sync status bit 3 did not toggle");
    a_dma_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_b6_repeat |=> distant_multiframe_alarm)
        else $error("distant alarm not raised");
    a_sa1_eval: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rx_line.mf_start |=> ts16_all_ones_alarm == ($past(ts16_zeros) < 8'd3))
        else $error("all ones alarm misjudged");
    a_rcl_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rx_line.bit_en && !rx_line.bit_val && zero_run == 8'd254 |=> carrier_loss_flag)
        else $error("carrier loss not declared");
    a_latch_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
        alarm_cond != 8'h00 |=> (alarm_latch & $past(alarm_cond)) == $past(alarm_cond))
        else $error("alarm event not latched");
    a_mask_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_status |=> receive_alarm_status ==
            (($past(receive_alarm_status) & ~$past(reg_wdata))
             | ($past(alarm_latch) & $past(reg_wdata))))
        else $error("masked status refresh wrong");
    a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (alarm_latch & alarm_irq_mask) == 8'h00 |-> !alarm_irq_out)
        else $error("interrupt without unmasked status");

endmodule : e1_receive_alarm_sync_status

// [verif/e1_line_model.sv]
// E1 receive line model driving the framer strobes of the alarm block
module e1_line_model (
    // Clock
    input  wire logic                 sys_clk,
    // Line strobes toward the block
    output e1_rx_alarm_pkg::rx_line_s rx_line
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Line driving tasks
    // ************************************************************
    // Quiet line at start
    initial begin
        rx_line = 8'h00;
    end

    // Run of equal line bits, optionally inside time slot 16
    task automatic send_bits(input int n, input logic val, input logic ts16);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            rx_line.bit_en   <= 1'b1;
            rx_line.bit_val  <= val;
            rx_line.ts16_bit <= ts16;
        end
        @(posedge sys_clk);
        rx_line.bit_en   <= 1'b0;
        rx_line.ts16_bit <= 1'b0;
        rx_line.bit_val  <= ~val;  // Released data shows the inverse
    endtask : send_bits

    // One strobe: 0 boundary, 1 distant bit, 2 remote bit, 3 slip
    task automatic pulse(input int kind, input logic val);
        @(posedge sys_clk);
        rx_line.bit_val     <= val;
        rx_line[4 - kind]   <= 1'b1;
        @(posedge sys_clk);
        rx_line[4:1]        <= 4'h0;
        rx_line.bit_val     <= ~val;
    endtask : pulse

    // Framer alignment level
    task automatic set_loss(input logic val);
        @(posedge sys_clk);
        rx_line.sync_loss <= val;
    endtask : set_loss
endmodule : e1_line_model

// [verif/e1_receive_alarm_sync_status_tb_top.sv]
// Self-checking testbench for the E1 receive alarm and sync status block
module e1_receive_alarm_sync_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TMO = 20;
    localparam logic [7:0] AS = e1_rx_alarm_pkg::ALARM_STATUS_ADDR;
    localparam logic [7:0] SS = e1_rx_alarm_pkg::SYNC_STATUS_ADDR;
    localparam logic [7:0] IM = e1_rx_alarm_pkg::IRQ_MASK_ADDR;

    logic                         sys_clk;
    logic                         rst_n;
    logic [7:0]                   reg_addr;
    logic                         reg_wr;
    logic                         reg_rd;
    logic [7:0]                   reg_wdata;
    logic [7:0]                   reg_rdata;
    e1_rx_alarm_pkg::rx_line_s    rx_line;
    e1_rx_alarm_pkg::sync_state_s sync_state;
    logic                         check_framing_enable;
    logic                         alarm_irq_out;
    int                           failures;
    int                           total_checks;

    // ************************************************************
    // Design, line model, clock
    // ************************************************************
    e1_receive_alarm_sync_status #(.SEARCH_TMO_CYCLES(TMO)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rx_line(rx_line), .sync_state(sync_state),
        .check_framing_enable(check_framing_enable), .alarm_irq_out(alarm_irq_out)
    );
    e1_line_model i_line (.sys_clk(sys_clk), .rx_line(rx_line));

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // Register access, compares, verdict
    // ************************************************************
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask : reg_read

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check8

    task automatic check1(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : check1

    task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        reg_read(a, d);
        check8("register", exp, d);
    endtask : check_reg

    // Mask write, read, write back of the masked value
    task automatic poll(input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] d;
        repeat (4) @(posedge sys_clk);
        reg_write(AS, m);
        reg_read(AS, d);
        check8("alarm status", exp, d);
        reg_write(AS, d & m);
    endtask : poll

    task automatic test_done;
        $display("Checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // Watchdog on the whole run
    initial begin
        repeat (100000) @(posedge sys_clk);
        failures++;
        test_done();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {rst_n, reg_wr, reg_rd, check_framing_enable} = 4'h0;
        {reg_addr, reg_wdata} = 16'h0000;
        sync_state = 4'h0;
        failures = 0;
        total_checks = 0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Reset values, unmapped and read-only places
        check_reg(IM, e1_rx_alarm_pkg::REG_RESET);
        check_reg(8'h3F, 8'h00);
        reg_write(SS, 8'hFF);
        check_reg(SS, 8'h00);
        poll(8'hFF, 8'h00);
        // Live search flags, counter held clear while CRC4 mode is off
        sync_state <= 4'hE;
        repeat (10 * TMO) @(posedge sys_clk);
        check_reg(SS, 8'h07);
        check_framing_enable <= 1'b1;
        sync_state <= 4'h2;
        repeat (5 * TMO + TMO / 2) @(posedge sys_clk);
        sync_state <= 4'h0;
        check_reg(SS, 8'h18);
        sync_state <= 4'h1;
        @(posedge sys_clk);
        sync_state <= 4'h0;
        check_reg(SS, 8'h00);
        sync_state <= 4'h2;
        repeat (65 * TMO + TMO / 4) @(posedge sys_clk);
        sync_state <= 4'h0;
        check_reg(SS, 8'h08);
        check_framing_enable <= 1'b0;
        check_reg(SS, 8'h00);
        // Carrier loss with interrupt
        reg_write(IM, 8'h02);
        check_reg(IM, 8'h02);
        i_line.send_bits(254, 1'b0, 1'b0);
        repeat (4) @(posedge sys_clk);
        check1("irq", 1'b0, alarm_irq_out);
        i_line.send_bits(1, 1'b0, 1'b0);
        repeat (4) @(posedge sys_clk);
        check1("irq", 1'b1, alarm_irq_out);
        poll(8'h02, 8'h02);
        poll(8'h02, 8'h02);
        poll(8'h00, 8'h02);
        i_line.send_bits(510, 1'b1, 1'b0);
        poll(8'h02, 8'h02);
        poll(8'h02, 8'h00);
        check1("irq", 1'b0, alarm_irq_out);
        // Remote and distant alarms
        repeat (2) i_line.pulse(2, 1'b1);
        poll(8'h04, 8'h00);
        i_line.pulse(2, 1'b1);
        poll(8'h04, 8'h04);
        repeat (2) i_line.pulse(2, 1'b0);
        poll(8'h04, 8'h04);
        i_line.pulse(2, 1'b0);
        poll(8'h04, 8'h04);
        poll(8'h04, 8'h00);
        i_line.pulse(1, 1'b1);
        poll(8'h40, 8'h00);
        i_line.pulse(1, 1'b1);
        poll(8'h40, 8'h40);
        repeat (2) i_line.pulse(1, 1'b0);
        poll(8'h40, 8'h40);
        poll(8'h40, 8'h00);
        // Slip event and loss of sync level
        i_line.pulse(3, 1'b1);
        poll(8'h10, 8'h10);
        poll(8'h10, 8'h00);
        i_line.set_loss(1'b1);
        poll(8'h01, 8'h01);
        i_line.set_loss(1'b0);
        poll(8'h01, 8'h01);
        poll(8'h01, 8'h00);
        // Time slot 16 multiframes: 3 zeros, 2 zeros, 3 zeros, all zeros, one one
        for (int z = 0; z < 5; z++) begin
            i_line.send_bits((z == 1) ? 2 : ((z > 2) ? 15 + (z & 1) : 3), 1'b0, 1'b1);
            i_line.send_bits((z == 1) ? 14 : ((z > 2) ? 1 - (z & 1) : 13), 1'b1, 1'b1);
            i_line.pulse(0, 1'b0);
            if (z < 3) begin
                poll(8'hA0, (z == 0) ? 8'h00 : 8'h80);
            end else begin
                poll(8'hA0, (z == 3) ? 8'h20 : 8'h20);
            end
        end
        poll(8'hA0, 8'h00);
        // Unframed ones
        i_line.send_bits(1024, 1'b1, 1'b0);
        poll(8'h08, 8'h08);
        i_line.send_bits(1024, 1'b0, 1'b0);
        poll(8'h08, 8'h08);
        poll(8'h08, 8'h00);
        test_done();
    end
endmodule : e1_receive_alarm_sync_status_tb_top
